// File: flow_fifo.sv
// Shared constants and the data FIFO used ahead of each transmitter
package flow_pkg;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 32;
    localparam int CHANNELS = 2;
    localparam int SYNC_SRCS = 3;
    localparam int ALT_SRC = 2;
    localparam logic RTS_RESET = 1'b1;
    localparam logic CTS_RESET = 1'b1;
    typedef enum logic {TX_IDLE, TX_SEND} tx_state_t;
endpackage : flow_pkg

////////////////////////////////////////////////////////////////////////////////
module flow_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    // Depth must be a power of two so the pointers wrap on their own
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = DEPTH[AW:0];

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW:0] next_count;
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;

    // Occupancy decode
    assign next_count = (push && !pop) ? count + 1'b1 :
                        (pop && !push) ? count - 1'b1 : count;
    assign out_valid_o = (count != '0);
    assign out_data_o = mem[rd_ptr];

    // Pointers, count and a registered ready so the source sees a clean flop
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready_o <= 1'b1;
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
            count <= next_count;
            in_ready_o <= (next_count != FULL_COUNT);
        end
    end

    // Storage needs no reset
    always_ff @(posedge clk_i)
    begin
        if (push)
            mem[wr_ptr] <= in_data_i;
    end
endmodule : flow_fifo

// File: flow_ctrl.sv
// Clear-to-send / request-to-send flow control for two serial channels
//
// Overview of operation
// - With clear-to-send on, a frame starts only while the input is low.
// - Clear-to-send rising mid-frame lets the frame finish, then holds later ones.
// - With request-to-send on, pin is driven low while receiver is ready.
// - Request-to-send goes high on start bit, stays high until ready again.
// - Pin active only when disable is 0; direction 1 output, 0 input.
// - Split mode: channel 0 drives its pin as output, reads alternate input.
// - Split mode needs channel 1 input-enabled and route select set to 1.
// - Split mode counts only while multi-clock output select is 0.
// - In split mode channel 1 flow control neither drives nor gates.
module flow_ctrl (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [1:0] tx_valid_i,
    input wire logic [15:0] tx_data_i,
    output logic [1:0] tx_ready_o,
    output logic [1:0] tx_start_o,
    output logic [15:0] tx_word_o,
    output logic [1:0] tx_busy_o,
    input wire logic [1:0] tx_done_i,
    input wire logic [1:0] rx_start_det_i,
    input wire logic [1:0] rx_ready_i,
    input wire logic [1:0] flow_pin_i,
    output logic [1:0] flow_pin_o,
    output logic [1:0] flow_pin_oe_o,
    input wire logic alt_cts_in_pin_i,
    input wire logic [1:0] flow_pin_disable_i,
    input wire logic [1:0] flow_pin_direction_select_i,
    input wire logic split_cts_route_select_i,
    input wire logic multi_clock_output_select_i,
    output logic split_active_o
);
    localparam int W = flow_pkg::DATA_W;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: three flops, level moves when stages two and three agree
    wire [flow_pkg::SYNC_SRCS-1:0] raw = {alt_cts_in_pin_i, flow_pin_i};
    logic [flow_pkg::SYNC_SRCS-1:0] filt;

    genvar s;
    generate
        for (s = 0; s < flow_pkg::SYNC_SRCS; s++)
        begin : g_sync
            logic s1;
            logic s2;
            logic s3;
            // Stage one feeds only stage two
            always_ff @(posedge clk_i or negedge nrst_i)
            begin
                if (!nrst_i)
                begin
                    s1 <= flow_pkg::CTS_RESET;
                    s2 <= flow_pkg::CTS_RESET;
                    s3 <= flow_pkg::CTS_RESET;
                    filt[s] <= flow_pkg::CTS_RESET;
                end
                else
                begin
                    s1 <= raw[s];
                    s2 <= s1;
                    s3 <= s2;
                    if (s2 == s3)
                        filt[s] <= s2;
                end
            end
            a_sync_agree: assert property (@(posedge clk_i) disable iff (!nrst_i)
                (filt[s] != $past(filt[s])) |-> $past(s2 == s3))
                else $error("synchronised level moved without agreement");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode: split mode needs the exact six-bit setting
    wire split = !flow_pin_disable_i[0] && flow_pin_direction_select_i[0]
        && !flow_pin_disable_i[1] && !flow_pin_direction_select_i[1]
        && split_cts_route_select_i
        && !multi_clock_output_select_i;

    // Gate and drive enables per channel
    wire [1:0] cts_gate;
    wire [1:0] rts_en;
    wire [1:0] cts_src;
    assign cts_gate[0] = split
        || (!flow_pin_disable_i[0] && !flow_pin_direction_select_i[0]);
    assign cts_gate[1] = !split && !flow_pin_disable_i[1]
        && !flow_pin_direction_select_i[1];
    assign rts_en[0] = !flow_pin_disable_i[0]
        && flow_pin_direction_select_i[0];
    assign rts_en[1] = !split && !flow_pin_disable_i[1]
        && flow_pin_direction_select_i[1];
    // Channel 0 reads the alternate pin in split mode
    assign cts_src[0] = split ? filt[flow_pkg::ALT_SRC] : filt[0];
    assign cts_src[1] = filt[1];

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            split_active_o <= 1'b0;
        else
            split_active_o <= split;
    end

    a_split_clk_off: assert property (@(posedge clk_i) disable iff (!nrst_i)
        multi_clock_output_select_i |=> !split_active_o)
        else $error("split mode reported while multi-clock output selected");

    ////////////////////////////////////////////////////////////////////////////
    // Per-channel FIFO, transmit gate and request-to-send
    genvar c;
    generate
        for (c = 0; c < flow_pkg::CHANNELS; c++)
        begin : g_ch
            flow_pkg::tx_state_t state;
            logic f_valid;
            logic [W-1:0] f_data;
            // Clear when gating is off or the synchronised line is low
            wire cts_ok = !cts_gate[c] || !cts_src[c];
            // Start bit wins over a same-cycle ready; pin flop holds the state
            wire next_rts = rx_start_det_i[c]
                || (!rx_ready_i[c] && flow_pin_o[c]);
            wire go = (state == flow_pkg::TX_IDLE) && f_valid && cts_ok;

            flow_fifo #(
                .WIDTH(W),
                .DEPTH(flow_pkg::FIFO_DEPTH)
            ) u_fifo (
                .clk_i(clk_i),
                .nrst_i(nrst_i),
                .in_valid_i(tx_valid_i[c]),
                .in_data_i(tx_data_i[c*W +: W]),
                .in_ready_o(tx_ready_o[c]),
                .out_valid_o(f_valid),
                .out_data_o(f_data),
                .out_ready_i(go)
            );

            // Checked only between frames, so a rising line never cuts one
            always_ff @(posedge clk_i or negedge nrst_i)
            begin
                if (!nrst_i)
                begin
                    state <= flow_pkg::TX_IDLE;
                    tx_start_o[c] <= 1'b0;
                    tx_busy_o[c] <= 1'b0;
                    tx_word_o[c*W +: W] <= '0;
                end
                else
                begin
                    tx_start_o[c] <= go;
                    unique case (state)
                        flow_pkg::TX_IDLE:
                        begin
                            if (go)
                            begin
                                state <= flow_pkg::TX_SEND;
                                tx_busy_o[c] <= 1'b1;
                                tx_word_o[c*W +: W] <= f_data;
                            end
                        end
                        flow_pkg::TX_SEND:
                        begin
                            if (tx_done_i[c])
                            begin
                                state <= flow_pkg::TX_IDLE;
                                tx_busy_o[c] <= 1'b0;
                            end
                        end
                    endcase
                end
            end

            // Pin drive; enable lags the setting by one cycle
            always_ff @(posedge clk_i or negedge nrst_i)
            begin
                if (!nrst_i)
                begin
                    flow_pin_o[c] <= flow_pkg::RTS_RESET;
                    flow_pin_oe_o[c] <= 1'b0;
                end
                else
                begin
                    flow_pin_o[c] <= next_rts;
                    flow_pin_oe_o[c] <= rts_en[c];
                end
            end

            a_start_needs_cts: assert property (@(posedge clk_i)
                disable iff (!nrst_i)
                tx_start_o[c] |-> $past(!cts_gate[c] || !cts_src[c]))
                else $error("frame started while clear-to-send high");
            a_start_when_clear: assert property (@(posedge clk_i)
                disable iff (!nrst_i)
                (!tx_busy_o[c] && f_valid && cts_ok) |=> tx_start_o[c])
                else $error("pending frame not started while clear");
            a_frame_not_cut: assert property (@(posedge clk_i)
                disable iff (!nrst_i)
                (tx_busy_o[c] && !tx_done_i[c]) |=> tx_busy_o[c])
                else $error("frame ended without its done strobe");
            a_rts_low_ready: assert property (@(posedge clk_i)
                disable iff (!nrst_i)
                (rx_ready_i[c] && !rx_start_det_i[c])
                    |=> !flow_pin_o[c] [*1])
                else $error("request-to-send not low while ready");
            a_rts_high_start: assert property (@(posedge clk_i)
                disable iff (!nrst_i)
                rx_start_det_i[c] ##1 !rx_ready_i[c] [*2]
                    |-> flow_pin_o[c] && $past(flow_pin_o[c]))
                else $error("request-to-send fell before receiver ready");
            a_pin_direction: assert property (@(posedge clk_i)
                disable iff (!nrst_i)
                flow_pin_oe_o[c] |-> $past(!flow_pin_disable_i[c]
                    && flow_pin_direction_select_i[c]))
                else $error("pin driven while disabled or set as input");
        end
    endgenerate

    a_split_cts_alt: assert property (@(posedge clk_i) disable iff (!nrst_i)
        ($past(split) && tx_start_o[0])
            |-> !$past(filt[flow_pkg::ALT_SRC]))
        else $error("channel 0 started with alternate input high");
    a_split_ch1_idle: assert property (@(posedge clk_i) disable iff (!nrst_i)
        split |=> !flow_pin_oe_o[1])
        else $error("channel 1 pin driven in split mode");
endmodule : flow_ctrl

// File: flow_remote.sv
// Remote serial device: drives clear-to-send and paces frames
module flow_remote #(
    parameter int LEN = 12
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [1:0] start_i,
    input wire logic [1:0] drive_i,
    input wire logic [1:0] oe_i,
    input wire logic [1:0] cts_i,
    input wire logic alt_i,
    output logic [1:0] level_o,
    output logic alt_o,
    output logic [1:0] done_o
);
    int cnt [2];
    // Pin level: device wins while enabled, remote drives otherwise
    assign level_o = (oe_i & drive_i) | (~oe_i & cts_i);
    assign alt_o = alt_i;
    ////////////////////////////////////////////////////////////////////////
    // Frame timer; a fixed length keeps the halt window predictable
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            done_o <= 2'b00;
            cnt <= '{0, 0};
        end
        else
        begin
            for (int c = 0; c < 2; c++)
            begin
                done_o[c] <= (cnt[c] == 1);
                if (start_i[c])
                    cnt[c] <= LEN;
                else if (cnt[c] > 0)
                    cnt[c] <= cnt[c] - 1;
            end
        end
    end
endmodule : flow_remote

// File: testbench.sv
// Self-checking bench for the two-channel flow control block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [1:0] tx_valid_i = 2'b00;
    logic [15:0] tx_data_i = 16'h0000;
    logic [1:0] rx_det = 2'b00;
    logic [1:0] rx_rdy = 2'b00;
    logic [1:0] dis = 2'b00;
    logic [1:0] dir = 2'b00;
    logic route = 1'b0;
    logic multi = 1'b0;
    logic [1:0] cts = 2'b11;
    logic alt = 1'b1;
    logic [1:0] allow = 2'b00;
    logic [1:0] rdy, start, busy, done, pin_o, oe, lvl;
    logic [15:0] word;
    logic alt_lvl, split;
    logic [7:0] q0 [$];
    logic [7:0] q1 [$];
    int failures = 0;
    int checks = 0;
    int starts [2] = '{0, 0};
    int n;
    flow_ctrl uut (.clk_i(clk_i), .nrst_i(nrst_i), .tx_valid_i(tx_valid_i),
        .tx_data_i(tx_data_i), .tx_ready_o(rdy), .tx_start_o(start),
        .tx_word_o(word), .tx_busy_o(busy), .tx_done_i(done),
        .rx_start_det_i(rx_det), .rx_ready_i(rx_rdy), .flow_pin_i(lvl),
        .flow_pin_o(pin_o), .flow_pin_oe_o(oe), .alt_cts_in_pin_i(alt_lvl),
        .flow_pin_disable_i(dis), .flow_pin_direction_select_i(dir),
        .split_cts_route_select_i(route), .multi_clock_output_select_i(multi),
        .split_active_o(split));
    flow_remote #(.LEN(12)) remote (.clk_i(clk_i), .nrst_i(nrst_i),
        .start_i(start), .drive_i(pin_o), .oe_i(oe), .cts_i(cts),
        .alt_i(alt), .level_o(lvl), .alt_o(alt_lvl), .done_o(done));
    always #5 clk_i = ~clk_i;
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic stop_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test
    task automatic step(input int k = 1);
        repeat (k) @(posedge clk_i);
        #1;
    endtask : step
    // Holds valid high until taken; caller lowers it once at the end
    task automatic push(input int c, input logic [7:0] d);
        logic r;
        tx_data_i[8*c +: 8] = d;
        tx_valid_i[c] = 1'b1;
        for (int i = 0; i < 100; i++)
        begin
            r = rdy[c];
            step();
            if (r === 1'b1)
                break;
        end
        if (c == 0)
            q0.push_back(d);
        else
            q1.push_back(d);
    endtask : push
    task automatic drain(input int c);
        for (int i = 0; i < 2000 && (c ? q1.size() : q0.size()) > 0; i++)
            step();
        check("drained", c ? q1.size() : q0.size(), 0);
    endtask : drain
    ////////////////////////////////////////////////////////////////////////
    // Model: every launched frame must be allowed and carry the oldest word
    always @(negedge clk_i)
    begin
        for (int c = 0; c < 2; c++)
            if (start[c] === 1'b1)
            begin
                starts[c]++;
                check("start_allowed", allow[c], 1'b1);
                check("queue", (c ? q1.size() : q0.size()) > 0, 1);
                check("word", word[8*c +: 8], c ? q1.pop_front()
                    : q0.pop_front());
            end
    end
    // Watchdog well past the expected run length
    initial
    begin
        #200us;
        failures++;
        stop_test();
    end
    initial
    begin
        n = $urandom(32'h268F4C2E);
        step(3);
        check("reset_out", {rdy, oe, pin_o, split}, 7'h66);
        nrst_i = 1'b1;
        // Fill channel 0 while clear-to-send stays high
        for (int i = 0; i < 32; i++)
            push(0, 8'($urandom));
        tx_data_i[7:0] = 8'hA5;
        step(3);
        tx_valid_i = 2'b00;
        check("fifo_full", rdy[0], 1'b0);
        check("no_start", starts[0], 0);
        allow[0] = 1'b1;
        cts[0] = 1'b0;
        for (int i = 0; i < 400 && starts[0] < 2; i++)
            step();
        cts[0] = 1'b1;
        allow[0] = 1'b0;
        step(5);
        check("busy_hold", busy[0], 1'b1);
        n = starts[0];
        step(40);
        check("halted", starts[0], n);
        allow[0] = 1'b1;
        cts[0] = 1'b0;
        drain(0);
        // Request-to-send on channel 1
        dir = 2'b10;
        step(2);
        check("oe_rts", oe, 2'b10);
        rx_rdy[1] = 1'b1;
        step();
        rx_rdy[1] = 1'b0;
        check("rts_ready", {lvl[1], pin_o[1]}, 2'b00);
        {rx_det[1], rx_rdy[1]} = 2'b11;
        step();
        {rx_det[1], rx_rdy[1]} = 2'b00;
        check("rts_start", pin_o[1], 1'b1);
        step(3);
        check("rts_hold", pin_o[1], 1'b1);
        // Disabled pins neither drive nor gate
        dis = 2'b11;
        cts = 2'b11;
        step(2);
        check("oe_off", oe, 2'b00);
        push(0, 8'($urandom));
        tx_valid_i = 2'b00;
        drain(0);
        // Split mode: channel 0 gated by alternate pin, channel 1 free
        {dis, dir, route} = 5'b00011;
        allow[1] = 1'b1;
        step(2);
        check("split_on", {split, oe}, 3'b101);
        allow[0] = 1'b0;
        push(0, 8'($urandom));
        // Drop channel 0 valid first so its word is not written twice
        tx_valid_i = 2'b00;
        step();
        push(1, 8'($urandom));
        tx_valid_i = 2'b00;
        drain(1);
        step(20);
        allow[0] = 1'b1;
        alt = 1'b0;
        drain(0);
        rx_rdy[0] = 1'b1;
        step();
        rx_rdy[0] = 1'b0;
        check("split_ready", pin_o[0], 1'b0);
        rx_det[0] = 1'b1;
        step();
        rx_det[0] = 1'b0;
        check("split_rts", {oe[0], pin_o[0]}, 2'b11);
        multi = 1'b1;
        allow[1] = 1'b0;
        step(2);
        check("split_off", split, 1'b0);
        push(1, 8'($urandom));
        tx_valid_i = 2'b00;
        step(20);
        allow[1] = 1'b1;
        cts[1] = 1'b0;
        drain(1);
        step(20);
        stop_test();
    end
endmodule : testbench
